/* File: include/tid_pkg.sv */
package tid_pkg;

    // ----------------------------------------------------------------
    // program memory map
    // ----------------------------------------------------------------
    localparam logic [13:0] TABLE_LO       = 14'h0020;
    localparam logic [13:0] TABLE_HI       = 14'h007F;
    localparam logic [13:0] TABLE_TGT_MAX  = 14'h3FFF;

    // ----------------------------------------------------------------
    // data memory bit areas
    // ----------------------------------------------------------------
    localparam logic [11:0] FMEM_A_LO      = 12'hFB0;
    localparam logic [11:0] FMEM_A_HI      = 12'hFBF;
    localparam logic [11:0] FMEM_B_LO      = 12'hFF0;
    localparam logic [11:0] PMEM_LO        = 12'hFC0;
    localparam logic [11:0] AREA_TOP       = 12'hFFF;
    localparam logic [3:0]  FIXED_BANK     = 4'hF;

    // ----------------------------------------------------------------
    // opcodes (internal encoding)
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_NOP          = 8'h00;
    localparam logic [7:0] OP_TIE          = 8'h01;
    localparam logic [7:0] OP_SKIP_NZ      = 8'h02;
    localparam logic [7:0] OP_STR_A        = 8'h03;
    localparam logic [7:0] OP_STR_B        = 8'h04;
    localparam logic [7:0] OP_INCS_L       = 8'h05;
    localparam logic [7:0] OP_BIT_SET      = 8'h10;
    localparam logic [7:0] OP_BIT_CLR      = 8'h11;
    localparam logic [7:0] OP_BIT_TST      = 8'h12;
    localparam logic [7:0] OP_BIT_MOV      = 8'h13;
    localparam logic [7:0] OP_BIT_AND      = 8'h14;
    localparam logic [7:0] OP_BIT_OR       = 8'h15;
    localparam logic [7:0] OP_BIT_XOR      = 8'h16;
    localparam logic [7:0] OP_BR_TBL       = 8'h40;
    localparam logic [7:0] OP_CALL_TBL     = 8'h80;
    localparam logic [1:0] ENT_KIND_BRANCH = 2'h1;
    localparam logic [1:0] ENT_KIND_CALL   = 2'h2;

    localparam logic [1:0] MODE_FMEM       = 2'h0;
    localparam logic [1:0] MODE_PMEM       = 2'h1;
    localparam logic [1:0] MODE_HMEM       = 2'h2;

    localparam logic [1:0] GRP_NONE        = 2'h0;
    localparam logic [1:0] GRP_A           = 2'h1;
    localparam logic [1:0] GRP_B           = 2'h2;

    localparam logic [13:0] PC_RESET       = 14'h0000;

    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_TBL   = 2'b01,
        ST_EXEC  = 2'b11
    } state_e;

    typedef struct packed {
        logic [1:0]  group;
        logic        is_skip;
        logic        is_bit;
        logic        is_tie;
    } decode_s;

    typedef struct packed {
        logic        valid;
        logic [11:0] addr;
        logic [2:0]  op;
    } bit_req_s;

endpackage : tid_pkg

/* File: logic/table_indirect_bit_decode.sv */
`timescale 1ns/1ps

module table_indirect_bit_decode
    import tid_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // program memory
    output logic [13:0]      pm_addr,
    input  wire logic [7:0]  pm_data,
    // core state
    input  wire logic        skip_cond,
    input  wire logic        bank_enable_flag,
    input  wire logic [3:0]  bank_select_value,
    input  wire logic [3:0]  ptr_low,
    input  wire logic [3:0]  ptr_high,
    // execution results
    output logic [13:0]      pc,
    output logic             call_req,
    output logic [13:0]      call_target,
    output logic             entry_fault,
    output bit_req_s         bit_req,
    output logic [3:0]       active_memory_bank,
    output logic             skip_flag
);

    // ----------------------------------------------------------------
    // shared decoding
    // ----------------------------------------------------------------
    // same decoder
    function automatic decode_s decode(input logic [7:0] op);
        decode_s d;
        d = '0;
        d.is_tie  = (op == OP_TIE);
        d.is_skip = (op == OP_SKIP_NZ) || (op == OP_INCS_L) || (op == OP_BIT_TST);
        d.is_bit  = (op[7:4] == 4'h1);
        d.group   = (op == OP_STR_A) ? GRP_A : (op == OP_STR_B) ? GRP_B : GRP_NONE;
        return d;
    endfunction : decode

    function automatic logic [11:0] bit_addr(input logic [1:0] mode, input logic [5:0] fld,
                                             input logic [3:0] mb, input logic [3:0] hp);
        logic [11:0] a;
        a = '0;
        case (mode)
            MODE_FMEM: a = fld[4] ? (FMEM_B_LO | {8'h00, fld[3:0]}) : (FMEM_A_LO | {8'h00, fld[3:0]});
            MODE_PMEM: a = PMEM_LO | {6'h00, fld[3:0], 2'b00};
            default:   a = {mb, hp, fld[3:0]};
        endcase
        return a;
    endfunction : bit_addr

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    state_e      state, next_state;
    logic [13:0] next_pc, next_pm_addr, next_call_target;
    logic [13:0] ret_pc, next_ret_pc;
    logic [7:0]  ent0, next_ent0;
    logic [1:0]  last_grp, next_last_grp;
    logic        next_skip_flag, next_call_req, next_entry_fault;
    bit_req_s    next_bit_req;
    logic [3:0]  next_mb;
    decode_s     dc;
    logic [3:0]  bit_sel;

    always_comb begin
        next_state       = state;
        next_pc          = pc;
        next_pm_addr     = pm_addr;
        next_ret_pc      = ret_pc;
        next_ent0        = ent0;
        next_last_grp    = last_grp;
        next_skip_flag   = skip_flag;
        next_call_req    = 1'b0;
        next_call_target = call_target;
        next_entry_fault = 1'b0;
        next_bit_req     = '0;
        next_mb          = bank_enable_flag ? bank_select_value : 4'h0;
        dc               = decode(pm_data);
        bit_sel          = ptr_low;
        case (state)
            ST_FETCH: begin
                next_pc      = 14'(pc + 14'd1);
                next_pm_addr = 14'(pc + 14'd1);
                if (skip_flag) begin
                    next_skip_flag = 1'b0;
                end else if (dc.is_tie) begin
                    next_ret_pc  = 14'(pc + 14'd1);
                    next_pm_addr = TABLE_LO;
                    next_state   = ST_TBL;
                end else if (dc.group != GRP_NONE && dc.group == last_grp) begin
                    next_last_grp = dc.group;
                end else begin
                    next_last_grp  = dc.group;
                    next_skip_flag = dc.is_skip && skip_cond;
                    if (dc.is_bit) begin
                        next_bit_req.valid = 1'b1;
                        next_bit_req.op    = pm_data[2:0];
                        next_bit_req.addr  = bit_addr(MODE_HMEM, {2'b00, bit_sel}, active_memory_bank, ptr_high);
                    end
                end
            end
            ST_TBL: begin
                next_ent0 = pm_data;
                next_pm_addr = 14'(pm_addr | 14'h0001);
                next_state   = ST_EXEC;
            end
            ST_EXEC: begin
                next_state   = ST_FETCH;
                next_pc      = ret_pc;
                next_pm_addr = ret_pc;
                if (ent0[7:6] == ENT_KIND_BRANCH || ent0[7:6] == ENT_KIND_CALL) begin
                    next_entry_fault = ({ent0[5:0], pm_data} > TABLE_TGT_MAX);
                    next_pc          = {ent0[5:0], pm_data};
                    next_pm_addr     = {ent0[5:0], pm_data};
                    next_call_req    = (ent0[7:6] == ENT_KIND_CALL);
                    next_call_target = {ent0[5:0], pm_data};
                    next_last_grp    = GRP_NONE;
                end else if (decode(ent0).group != GRP_NONE) begin
                    next_last_grp = decode(ent0).group;
                end else begin
                    next_skip_flag = decode(ent0).is_skip && skip_cond;
                    next_last_grp  = GRP_NONE;
                    if (decode(ent0).is_bit) begin
                        next_bit_req.valid = 1'b1;
                        next_bit_req.op    = ent0[2:0];
                        // indirect mode uses the active bank
                        next_bit_req.addr  = bit_addr(pm_data[7:6], pm_data[5:0], active_memory_bank, ptr_high);
                    end
                end
            end
            default: next_state = ST_FETCH;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state              <= ST_FETCH;
            pc                 <= PC_RESET;
            pm_addr            <= PC_RESET;
            ret_pc             <= PC_RESET;
            ent0               <= OP_NOP;
            last_grp           <= GRP_NONE;
            skip_flag          <= 1'b0;
            call_req           <= 1'b0;
            call_target        <= PC_RESET;
            entry_fault        <= 1'b0;
            bit_req            <= '0;
            active_memory_bank <= 4'h0;
        end else begin
            state              <= next_state;
            pc                 <= next_pc;
            pm_addr            <= next_pm_addr;
            ret_pc             <= next_ret_pc;
            ent0               <= next_ent0;
            last_grp           <= next_last_grp;
            skip_flag          <= next_skip_flag;
            call_req           <= next_call_req;
            call_target        <= next_call_target;
            entry_fault        <= next_entry_fault;
            bit_req            <= next_bit_req;
            active_memory_bank <= next_mb;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence tie_taken_s;
        state == ST_FETCH && !skip_flag && pm_data == OP_TIE;
    endsequence

    tie_to_table_a: assert property (@(posedge clk) disable iff (!resetn)
        tie_taken_s |=> state == ST_TBL && pm_addr == TABLE_LO)
        else $error("table fetch not at table base");
    return_pc_a: assert property (@(posedge clk) disable iff (!resetn)
        tie_taken_s |=> ##1 (state == ST_EXEC && ent0[7:6] == 2'b00) |=> pc == $past(ret_pc))
        else $error("pc not returned after entry");
    skip_one_a: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_FETCH && skip_flag) |=> !skip_flag && state == ST_FETCH)
        else $error("skip not one cycle");
    bank_form_a: assert property (@(posedge clk) disable iff (!resetn)
        ##1 active_memory_bank == ($past(bank_enable_flag) ? $past(bank_select_value) : 4'h0))
        else $error("bank formed wrong");
    call_range_a: assert property (@(posedge clk) disable iff (!resetn)
        call_req |-> $past(state) == ST_EXEC)
        else $error("call outside entry execution");
    fmem_area_a: assert property (@(posedge clk) disable iff (!resetn)
        (bit_req.valid && $past(state) == ST_EXEC && $past(pm_data[7:6]) == MODE_FMEM)
        |-> (bit_req.addr[11:4] == FMEM_A_LO[11:4] || bit_req.addr[11:4] == FMEM_B_LO[11:4]))
        else $error("fixed bit address out of area");
    pmem_area_a: assert property (@(posedge clk) disable iff (!resetn)
        (bit_req.valid && $past(state) == ST_EXEC && $past(pm_data[7:6]) == MODE_PMEM)
        |-> bit_req.addr >= PMEM_LO)
        else $error("port bit address out of area");
    string_run_a: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_FETCH && !skip_flag && decode(pm_data).group != GRP_NONE
         && decode(pm_data).group == last_grp) |=> !skip_flag && !bit_req.valid)
        else $error("string run not treated as nop");

endmodule : table_indirect_bit_decode

/* File: verification/pm_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// program memory partner: rom read in the same cycle as the address
// ----------------------------------------------------------------
module pm_model (
    // clock
    input  wire logic        clk,
    // read port
    input  wire logic [13:0] pm_addr,
    output logic [7:0]       pm_data
);
    logic [7:0] mem [0:16383];

    // aligned table pairs
    // the bench fills even/odd table bytes; the sequencer decodes the byte at
    // its registered address on the next edge, so the read must not add a cycle
    assign pm_data = mem[pm_addr];
endmodule : pm_model

/* File: verification/tb_top.sv */
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end

module tb_top;
    import tid_pkg::*;

    logic        clk               = 1'b0;
    logic        resetn            = 1'b0;
    logic [13:0] pm_addr;
    logic [7:0]  pm_data;
    logic        skip_cond         = 1'b0;
    logic        bank_enable_flag  = 1'b0;
    logic [3:0]  bank_select_value = 4'h0;
    logic [3:0]  ptr_low           = 4'h0;
    logic [3:0]  ptr_high          = 4'h0;
    logic [13:0] pc;
    logic        call_req;
    logic [13:0] call_target;
    logic        entry_fault;
    bit_req_s    bit_req;
    bit_req_s    cap;
    logic [3:0]  active_memory_bank;
    logic        skip_flag;
    logic [31:0] seed              = 32'h0000_0038;
    logic [13:0] tgt;
    logic [1:0]  md;
    int          n_mismatch        = 0;
    int          check_count       = 0;
    int          n_call, n_bit, n_tbl;

    always #2 clk = ~clk;

    table_indirect_bit_decode table_indirect_bit_decode_inst (
        .clk(clk), .resetn(resetn), .pm_addr(pm_addr), .pm_data(pm_data),
        .skip_cond(skip_cond), .bank_enable_flag(bank_enable_flag),
        .bank_select_value(bank_select_value), .ptr_low(ptr_low), .ptr_high(ptr_high),
        .pc(pc), .call_req(call_req), .call_target(call_target), .entry_fault(entry_fault),
        .bit_req(bit_req), .active_memory_bank(active_memory_bank), .skip_flag(skip_flag)
    );

    pm_model pm_model_inst (.clk(clk), .pm_addr(pm_addr), .pm_data(pm_data));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    // pmem reaches fc0-fff, fmem only the two 16-bit windows
    function automatic logic area_ok(input logic [1:0] mode, input logic [11:0] a);
        if (mode == MODE_FMEM) return (a >= FMEM_A_LO && a <= FMEM_A_HI) || a >= FMEM_B_LO;
        if (mode == MODE_PMEM) return a >= PMEM_LO;
        return 1'b1;
    endfunction : area_ok

    task automatic end_of_test();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // load a two-byte program and one table entry, reset, then watch 14 cycles
    task automatic run(input logic [7:0] p0, p1, b0, b1, input logic sk);
        for (int a = 0; a < 16384; a++) pm_model_inst.mem[a] = OP_NOP;
        pm_model_inst.mem[0] = p0;
        pm_model_inst.mem[1] = p1;
        pm_model_inst.mem[TABLE_LO] = b0;
        pm_model_inst.mem[TABLE_LO + 14'h0001] = b1;
        @(posedge clk);
        resetn    <= 1'b0;
        skip_cond <= sk;
        ptr_low   <= seed[11:8];
        ptr_high  <= seed[15:12];
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        n_call = 0;
        n_bit  = 0;
        n_tbl  = 0;
        repeat (14) begin
            @(posedge clk);
            #1;
            if (call_req === 1'b1) n_call++;
            if (bit_req.valid === 1'b1) begin
                n_bit++;
                cap = bit_req;
            end
            if (pm_addr === TABLE_LO) n_tbl++;
        end
    endtask : run

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            tgt = {seed[13:8] | 6'h01, seed[7:0]};
            run(OP_TIE, OP_NOP, {i[0] ? ENT_KIND_CALL : ENT_KIND_BRANCH, tgt[13:8]}, tgt[7:0], 1'b0);
            `CHK("call_req count", i[0] ? 1 : 0, n_call)
            `CHK("call_target", tgt, call_target)
            `CHK("table fetch", 1, n_tbl)
        end
        for (int op = 0; op < 7; op++) begin
            seed = xs(seed);
            md = 2'(op % 3);
            run(OP_TIE, OP_NOP, OP_BIT_SET + 8'(op), {md, seed[5:0]}, 1'b0);
            `CHK("bit_req count", 1, n_bit)
            `CHK("bit op", 3'(op), cap.op)
            `CHK("bit area", 1'b1, area_ok(md, cap.addr))
            if (md == MODE_HMEM) `CHK("hmem bank", 4'h0, cap.addr[11:8])
        end
        // taken skip drops the table opcode before it fetches anything
        run(OP_SKIP_NZ, OP_TIE, {ENT_KIND_CALL, 6'h01}, 8'h00, 1'b1);
        `CHK("skipped table fetch", 0, n_tbl)
        `CHK("skipped call", 0, n_call)
        // paired one-byte entry: return after the table opcode
        run(OP_TIE, OP_NOP, OP_NOP, OP_INCS_L, 1'b0);
        `CHK("pair return pc", 14'd12, pc)
        // string run: second of the group acts as no-operation
        run(OP_STR_A, OP_STR_A, OP_NOP, OP_NOP, 1'b1);
        `CHK("string run bit", 0, n_bit)
        `CHK("string run skip", 1'b0, skip_flag)
        for (int k = 0; k < 2; k++) begin
            run(OP_TIE, OP_TIE, OP_SKIP_NZ, OP_NOP, k[0]);
            `CHK("entry skip fetches", k[0] ? 1 : 2, n_tbl)
        end
        for (int j = 0; j < 8; j++) begin
            seed = xs(seed);
            @(posedge clk);
            bank_enable_flag  <= seed[0];
            bank_select_value <= seed[4:1];
            @(posedge clk);
            #1;
            `CHK("active bank", seed[0] ? seed[4:1] : 4'h0, active_memory_bank)
        end
        end_of_test();
    end

    // about 320 cycles expected; generous margin before calling it a hang
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
endmodule : tb_top
